// [design/sbdp_target.sv]
/*
 * target end of the single-pin debug port: mode strap, bit receiver and
 * transmitter, command decoder, status, saved condition codes, page pointer
 * and breakpoint routing.
 * assumes pclk is the vco clock and the line is synchronous to it.
 */
// Chosen here: register access through link command and data bytes.
`timescale 1ns/1ps
`default_nettype none
module sbdp_target
    import sbdp_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // debug line
    sbdp_link_if.target     link,
    // security state
    input  wire logic       secured,
    input  wire logic       erased,
    // breakpoint routing
    input  wire logic       bkpt_req,
    input  wire logic       bkpt_to_debug,
    output logic            debug_entry,
    output logic            trap_req,
    // mode and state
    output logic            special_mode,
    output logic            debug_active,
    // register contents
    output logic [7:0]      ccr_out,
    output logic [7:0]      ppr_out
);

    logic              mode_done_q;
    logic              special_q;
    logic              enable_q;
    logic              active_q;
    logic [7:0]        ccr_q;
    logic [7:0]        ppr_q;
    logic              entry_q;
    logic              trap_q;
    logic [2:0]        div_q;
    logic              line_q;
    logic              pend_q;
    logic              in_bit_q;
    logic [4:0]        tc_q;
    logic [9:0]        to_q;
    sbdp_tstate_e      st_q;
    logic [2:0]        bitn_q;
    logic [7:0]        sr_q;
    logic [7:0]        cmd_q;
    logic              txbit_q;
    logic              txact_q;
    logic              oe_n_q;
    logic              out_q;
    logic              oe_n_d;
    logic              out_d;
    logic              tick;
    logic              fall;
    logic              samp;
    logic              abort;
    logic [7:0]        rx_byte;
    logic              rd_ok;

    function automatic logic [7:0] reg_read(input logic [3:0] idx, input logic ok);
        logic [7:0] v;
        v = 8'h00;
        if (ok) begin
            case (idx)
                IDX_STATUS: begin
                    v[ST_ENABLE_BIT] = enable_q;
                    v[ST_ACTIVE_BIT] = active_q;
                    v[ST_UNLOCK_BIT] = special_q & secured & erased;
                end
                IDX_CCR: v = ccr_q;
                IDX_PPR: v = ppr_q;
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    // reads are blocked while secured and not erased
    assign rd_ok   = ~secured | erased;
    assign tick    = ce && (div_q == 3'(VCO_DIV - 1));
    assign fall    = ce && mode_done_q && line_q && !link.line;
    assign samp    = tick && in_bit_q && (tc_q == 5'(SAMPLE_TC));
    assign abort   = tick && (st_q != TS_CMD || bitn_q != 3'd0)
                     && (to_q == 10'(TIMEOUT_TC - 1)) && !fall;
    assign rx_byte = {sr_q[6:0], link.line};

    // strap caught on the first enabled edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_done_q <= 1'b0;
            special_q   <= 1'b0;
        end else if (ce && !mode_done_q) begin
            special_q   <= ~link.line;
            mode_done_q <= 1'b1;
        end
    end

    // target clock divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 3'd0;
        end else if (ce) begin
            div_q <= div_q + 3'd1;
        end
    end

    // edge recognition and in-bit timing from the perceived edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_q   <= 1'b1;
            pend_q   <= 1'b0;
            in_bit_q <= 1'b0;
            tc_q     <= 5'd0;
        end else if (ce) begin
            line_q <= link.line;
            if (fall) begin
                pend_q <= 1'b1;
            end else if (tick && pend_q) begin
                pend_q   <= 1'b0;
                in_bit_q <= 1'b1;
                tc_q     <= 5'd0;
            end else if (abort) begin
                in_bit_q <= 1'b0;
            end else if (tick && in_bit_q && tc_q != 5'd31) begin
                tc_q <= tc_q + 5'd1;
            end
        end
    end

    // timeout counter between host edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_q <= 10'd0;
        end else if (ce) begin
            if (fall || abort) begin
                to_q <= 10'd0;
            end else if (tick && to_q != 10'h3FF) begin
                to_q <= to_q + 10'd1;
            end
        end
    end

    // bit and byte sequencing, command decode and register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= TS_CMD;
            bitn_q  <= 3'd0;
            sr_q    <= 8'h00;
            cmd_q   <= 8'h00;
            txbit_q <= 1'b1;
            txact_q <= 1'b0;
            ccr_q   <= CCR_RST;
            ppr_q   <= PPR_RST;
        end else if (ce) begin
            if (abort) begin
                st_q    <= TS_CMD;
                bitn_q  <= 3'd0;
                txact_q <= 1'b0;
            end else if (tick && pend_q) begin
                txact_q <= (st_q == TS_RDATA);
                txbit_q <= sr_q[7];
            end else if (samp) begin
                bitn_q <= bitn_q + 3'd1;
                if (st_q == TS_RDATA) begin
                    sr_q <= {sr_q[6:0], 1'b0};
                end else begin
                    sr_q <= rx_byte;
                end
                if (bitn_q == 3'd7) begin
                    case (st_q)
                        TS_CMD: begin
                            cmd_q <= rx_byte;
                            if (rx_byte[CMD_READ_BIT]) begin
                                sr_q <= reg_read(rx_byte[3:0], rd_ok);
                                st_q <= TS_RDATA;
                            end else begin
                                st_q <= TS_WDATA;
                            end
                        end
                        TS_WDATA: begin
                            st_q <= TS_CMD;
                            if (rd_ok && cmd_q[3:0] == IDX_CCR) begin
                                ccr_q <= rx_byte;
                            end
                            if (rd_ok && cmd_q[3:0] == IDX_PPR) begin
                                ppr_q <= rx_byte & {1'b1, 3'b000, {(PPR_PAGE_MSB + 1){1'b1}}};
                            end
                        end
                        default: st_q <= TS_CMD;
                    endcase
                end
            end
        end
    end

    // debug enable flag, background state and breakpoint routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= 1'b0;
            active_q <= 1'b0;
            entry_q  <= 1'b0;
            trap_q   <= 1'b0;
        end else if (ce) begin
            entry_q <= 1'b0;
            trap_q  <= 1'b0;
            if (!mode_done_q) begin
                enable_q <= ~link.line & (~secured | erased);
            end else if (samp && bitn_q == 3'd7 && st_q == TS_WDATA && rd_ok
                         && cmd_q[3:0] == IDX_STATUS) begin
                enable_q <= rx_byte[ST_ENABLE_BIT];
                if (!rx_byte[ST_ACTIVE_BIT]) begin
                    active_q <= 1'b0;
                end
            end
            if (bkpt_req) begin
                if (bkpt_to_debug && enable_q) begin
                    entry_q  <= 1'b1;
                    active_q <= 1'b1;
                end else begin
                    trap_q <= 1'b1;
                end
            end
        end
    end

    // line drive while answering: low for zero, speedup high for one
    always_comb begin
        oe_n_d = 1'b1;
        out_d  = 1'b1;
        if (txact_q && in_bit_q) begin
            if (!txbit_q && tc_q < 5'(ZERO_LOW_TC)) begin
                oe_n_d = 1'b0;
                out_d  = 1'b0;
            end else if (txbit_q && tc_q == 5'(DEV_SPEEDUP_TC)) begin
                oe_n_d = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_n_q <= 1'b1;
            out_q  <= 1'b1;
        end else if (ce) begin
            oe_n_q <= oe_n_d;
            out_q  <= out_d;
        end
    end

    assign link.dev_oe_n = oe_n_q;
    assign link.dev_out  = out_q;
    assign special_mode  = special_q;
    assign debug_active  = active_q;
    assign debug_entry   = entry_q;
    assign trap_req      = trap_q;
    assign ccr_out       = ccr_q;
    assign ppr_out       = ppr_q;

endmodule // sbdp_target
`default_nettype wire

// [design/sbdp_pkg.sv]
/*
 * shared constants and types of the single-pin background debug port:
 * bit timing in target clocks, target register map, command layout and
 * the host controller's APB register map.
 * assumes pclk is the vco clock of the target and clocks both ends.
 */
// Contract
// - pin selects mode while reset held
// - after reset pin serves only debug link
// - target clock is vco clock divided eight
// - host starts every bit with falling edge
// - msb first, sixteen target clocks per bit
// - 512 clocks without edge abandons transfer
// - pseudo open drain, weak pull-up always on
// - drivers drive low, high only speedup
// - transmitter gives brief driven-high speedup pulse; here the target gives it only for a one
// - target times bits from recognised edge
// - host times bits from its drive
// - debug enable reads one in special mode; here only when unsecured or erased
// - unsecured flag only when secured and erased
// - breakpoint without debug enable becomes trap
`default_nettype none
package sbdp_pkg;
    // target clock and bit timing, in target clocks
    localparam int VCO_DIV        = 8;
    localparam int BIT_TC         = 16;
    localparam int ONE_LOW_TC     = 4;
    localparam int ZERO_LOW_TC    = 13;
    localparam int SAMPLE_TC      = 10;
    localparam int DEV_SPEEDUP_TC = 7;
    localparam int TIMEOUT_TC     = 512;
    // host timing in pclk cycles
    localparam logic [7:0] H_ONE_LOW  = 8'(ONE_LOW_TC * VCO_DIV);
    localparam logic [7:0] H_ZERO_LOW = 8'(ZERO_LOW_TC * VCO_DIV);
    localparam logic [7:0] H_SPEEDUP  = 8'(VCO_DIV);
    localparam logic [7:0] H_SAMPLE   = 8'(SAMPLE_TC * VCO_DIV);
    localparam logic [7:0] H_BIT_LAST = 8'(BIT_TC * VCO_DIV - 1);
    // target register map, global offsets and the index carried in commands
    localparam logic [19:0] OFS_STATUS = 20'h3FF01;
    localparam logic [19:0] OFS_CCR    = 20'h3FF06;
    localparam logic [19:0] OFS_PPR    = 20'h3FF08;
    localparam logic [3:0]  IDX_STATUS = OFS_STATUS[3:0];
    localparam logic [3:0]  IDX_CCR    = OFS_CCR[3:0];
    localparam logic [3:0]  IDX_PPR    = OFS_PPR[3:0];
    localparam int ST_ENABLE_BIT = 7;
    localparam int ST_ACTIVE_BIT = 6;
    localparam int ST_UNLOCK_BIT = 1;
    localparam int PPR_PAE_BIT   = 7;
    localparam int PPR_PAGE_MSB  = 3;
    localparam logic [7:0] CCR_RST = 8'h00;
    localparam logic [7:0] PPR_RST = 8'h00;
    // command byte: read flag and register index
    localparam int CMD_READ_BIT = 7;
    // host controller APB map
    localparam logic [11:0] H_CTRL_OFS  = 12'h000;
    localparam logic [11:0] H_STAT_OFS  = 12'h004;
    localparam logic [11:0] H_RDATA_OFS = 12'h008;
    localparam int CTRL_GO_BIT   = 16;
    localparam int CTRL_HOLD_BIT = 17;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    typedef enum logic [1:0] {TS_CMD, TS_WDATA, TS_RDATA} sbdp_tstate_e;
endpackage
`default_nettype wire

// [design/sbdp_link_if.sv]
/*
 * the single debug line between host and target.
 * assumes each end drives only through its out and active-low enable.
 */
`timescale 1ns/1ps
`default_nettype none
interface sbdp_link_if;
    logic dev_out;
    logic dev_oe_n;
    logic host_out;
    logic host_oe_n;
    logic line;
    // any low driver wins, else pull-up or speedup gives one
    assign line = ~((~dev_oe_n & ~dev_out) | (~host_oe_n & ~host_out));
    modport target (input line, output dev_out, output dev_oe_n);
    modport host   (input line, output host_out, output host_oe_n);
endinterface
`default_nettype wire

// [design/sbdp_host.sv]
/*
 * host end of the single-pin debug port: APB registers, mode strap drive
 * and a sixteen-bit command engine (command byte then data byte).
 * assumes pclk is shared with the target and APB is synchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none
module sbdp_host
    import sbdp_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // debug line
    sbdp_link_if.host        link
);

    logic [7:0]  cmd_q;
    logic [7:0]  wdata_q;
    logic        hold_q;
    logic        busy_q;
    logic        done_q;
    logic [7:0]  rdata_q;
    logic [15:0] sr_q;
    logic [3:0]  bitn_q;
    logic [7:0]  cyc_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        oe_n_q;
    logic        out_q;
    logic        oe_n_d;
    logic        out_d;
    logic        acc;
    logic        tx;
    logic [7:0]  low_len;
    logic        finish;

    assign acc    = psel && penable && pready_q;
    assign tx     = !bitn_q[3] || !cmd_q[CMD_READ_BIT];
    assign low_len = (tx && !sr_q[15]) ? H_ZERO_LOW : H_ONE_LOW;
    assign finish = ce && busy_q && bitn_q == 4'hF && cyc_q == H_BIT_LAST;

    // apb: one wait-free access phase, read data prepared in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce) begin
            pready_q  <= psel && !penable && !pready_q;
            if (psel && !penable) begin
                pslverr_q <= !(paddr == H_CTRL_OFS || paddr == H_STAT_OFS
                               || paddr == H_RDATA_OFS);
                case (paddr)
                    H_CTRL_OFS:  prdata_q <= {14'h0000, hold_q, 1'b0, wdata_q, cmd_q};
                    H_STAT_OFS:  prdata_q <= {30'h0000_0000, done_q, busy_q};
                    H_RDATA_OFS: prdata_q <= {24'h00_0000, rdata_q};
                    default:     prdata_q <= 32'h0000_0000;
                endcase
            end else if (acc) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // control registers and command engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q   <= 8'h00;
            wdata_q <= 8'h00;
            hold_q  <= 1'b0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            rdata_q <= 8'h00;
            sr_q    <= 16'h0000;
            bitn_q  <= 4'h0;
            cyc_q   <= 8'h00;
        end else if (ce) begin
            // set wins over a clear in the same cycle
            done_q <= finish || (done_q && !(acc && pwrite && paddr == H_STAT_OFS
                                            && pwdata[STAT_DONE_BIT]));
            if (acc && pwrite && paddr == H_CTRL_OFS && !busy_q) begin
                cmd_q   <= pwdata[7:0];
                wdata_q <= pwdata[15:8];
                hold_q  <= pwdata[CTRL_HOLD_BIT];
                if (pwdata[CTRL_GO_BIT]) begin
                    busy_q <= 1'b1;
                    sr_q   <= pwdata[15:0] == 16'h0000 ? 16'h0000
                              : {pwdata[7:0], pwdata[15:8]};
                    bitn_q <= 4'h0;
                    cyc_q  <= 8'h00;
                end
            end else if (ce && busy_q) begin
                if (!tx && cyc_q == H_SAMPLE) begin
                    rdata_q <= {rdata_q[6:0], link.line};
                end
                if (cyc_q == H_BIT_LAST) begin
                    cyc_q  <= 8'h00;
                    sr_q   <= {sr_q[14:0], 1'b0};
                    bitn_q <= bitn_q + 4'h1;
                    if (bitn_q == 4'hF) begin
                        busy_q <= 1'b0;
                    end
                end else begin
                    cyc_q <= cyc_q + 8'h01;
                end
            end
        end
    end

    // line drive: low at every bit start, speedup only when sending
    always_comb begin
        oe_n_d = 1'b1;
        out_d  = 1'b1;
        if (busy_q) begin
            if (cyc_q < low_len) begin
                oe_n_d = 1'b0;
                out_d  = 1'b0;
            end else if (tx && cyc_q < low_len + H_SPEEDUP) begin
                oe_n_d = 1'b0;
            end
        end else if (hold_q) begin
            oe_n_d = 1'b0;
            out_d  = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_n_q <= 1'b1;
            out_q  <= 1'b1;
        end else if (ce) begin
            oe_n_q <= oe_n_d;
            out_q  <= out_d;
        end
    end

    assign link.host_oe_n = oe_n_q;
    assign link.host_out  = out_q;
    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;

endmodule // sbdp_host
`default_nettype wire

// [sim/sbdp_properties.sv]
/*
 * line-level checks of the debug link between host and target ends.
 * assumes the bench hands in the interface signals and the host reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sbdp_properties (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // line drivers
    input wire logic dev_out,
    input wire logic dev_oe_n,
    input wire logic host_out,
    input wire logic host_oe_n,
    input wire logic line
);
    logic       h_lo;
    logic       h_hi;
    logic       d_lo;
    logic       d_hi;
    logic       h_lo_q;
    logic [8:0] hcnt_q;
    logic [8:0] dcnt_q;
    logic [7:0] gap_q;

    assign h_lo = ~host_oe_n & ~host_out;
    assign h_hi = ~host_oe_n & host_out;
    assign d_lo = ~dev_oe_n & ~dev_out;
    assign d_hi = ~dev_oe_n & dev_out;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // length of the host low pulse so far
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hcnt_q <= 9'h000;
        else if (!h_lo) hcnt_q <= 9'h000;
        else if (hcnt_q != 9'h1FF) hcnt_q <= hcnt_q + 9'h001;
    end
    // length of the target low pulse so far
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) dcnt_q <= 9'h000;
        else if (!d_lo) dcnt_q <= 9'h000;
        else if (dcnt_q != 9'h1FF) dcnt_q <= dcnt_q + 9'h001;
    end
    // cycles since the last host falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) h_lo_q <= 1'b0;
        else h_lo_q <= h_lo;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gap_q <= 8'hFF;
        else if (h_lo && !h_lo_q) gap_q <= 8'h00;
        else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
    end

    host_low_len_a: assert property ($fell(h_lo) |-> hcnt_q == 9'h020 ||
        hcnt_q == 9'h068 || hcnt_q > 9'h0C8)
        else $error("host low pulse has a wrong length");
    bit_space_a: assert property ($rose(h_lo) |-> gap_q >= 8'h7F)
        else $error("host bit starts closer than one bit time");
    host_spd_len_a: assert property ($rose(h_hi) |-> h_hi[*8] ##1 !h_hi)
        else $error("host speedup pulse not eight cycles");
    host_spd_after_a: assert property ($rose(h_hi) |-> $past(h_lo))
        else $error("host speedup not right after its low pulse");
    dev_low_start_a: assert property ($rose(d_lo) |-> h_lo && gap_q <= 8'h0A)
        else $error("target low drive not started by a host edge");
    dev_low_len_a: assert property ($fell(d_lo) |-> dcnt_q == 9'h068)
        else $error("target low pulse not thirteen target clocks");
    dev_spd_time_a: assert property ($rose(d_hi) |-> gap_q inside {[8'h36:8'h42]})
        else $error("target speedup at wrong point of the bit");
    dev_spd_len_a: assert property ($rose(d_hi) |-> ##[1:8] !d_hi)
        else $error("target speedup pulse too long");
    no_fight_a: assert property (!(d_hi && h_lo) && !(h_hi && d_lo))
        else $error("both ends drive opposite levels");
    line_res_a: assert property (line == !(h_lo || d_lo))
        else $error("line level differs from its drivers");
endmodule // sbdp_properties
`default_nettype wire

// [sim/sbdp_tb.sv]
/*
 * bench joining host and target ends: apb stimulus, mode strap, link transfers.
 * assumes the design files and the line checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module sbdp_tb
    import sbdp_pkg::*;
;
    logic        pclk, presetn, tgt_rstn, secured, erased, bkpt_req, bkpt_to_debug;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        debug_entry, trap_req, special_mode, debug_active;
    logic [7:0]  ccr_out, ppr_out;
    int          num_errors, checked;

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    sbdp_link_if u_sbdp_link_if ();
    sbdp_host u_sbdp_host (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(u_sbdp_link_if));
    sbdp_target u_sbdp_target (.pclk(pclk), .presetn(tgt_rstn), .ce(1'b1),
        .link(u_sbdp_link_if), .secured(secured), .erased(erased), .bkpt_req(bkpt_req),
        .bkpt_to_debug(bkpt_to_debug), .debug_entry(debug_entry), .trap_req(trap_req),
        .special_mode(special_mode), .debug_active(debug_active), .ccr_out(ccr_out),
        .ppr_out(ppr_out));
    sbdp_properties u_sbdp_properties (.pclk(pclk), .presetn(presetn),
        .dev_out(u_sbdp_link_if.dev_out), .dev_oe_n(u_sbdp_link_if.dev_oe_n),
        .host_out(u_sbdp_link_if.host_out), .host_oe_n(u_sbdp_link_if.host_oe_n),
        .line(u_sbdp_link_if.line));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one sixteen-bit link command, then fetch the received byte
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd);
        logic got;
        got = 1'b0;
        apb(1'b1, H_CTRL_OFS, {15'h0000, 1'b1, wd, cmd});
        for (int i = 0; i < 1500; i++) begin
            apb(1'b0, H_STAT_OFS, 32'h0);
            if (rd[STAT_DONE_BIT] === 1'b1) begin
                got = 1'b1;
                break;
            end
        end
        chk({31'h0, got}, 32'h1);
        apb(1'b1, H_STAT_OFS, 32'h2);
        apb(1'b0, H_RDATA_OFS, 32'h0);
    endtask

    task automatic bkpt(input logic [1:0] exp);
        logic [1:0] seen;
        seen = 2'h0;
        @(posedge pclk);
        bkpt_req <= 1'b1;
        @(posedge pclk);
        bkpt_req <= 1'b0;
        repeat (4) begin
            @(negedge pclk);
            seen = seen | {debug_entry, trap_req};
        end
        chk(32'(seen), 32'(exp));
    endtask

    // target reset with the line held low or released by the host
    task automatic strap(input logic hold);
        apb(1'b1, H_CTRL_OFS, {14'h0000, hold, 17'h00000});
        tgt_rstn <= 1'b0;
        repeat (5) @(posedge pclk);
        tgt_rstn <= 1'b1;
        repeat (250) @(posedge pclk);
        apb(1'b1, H_CTRL_OFS, 32'h0);
        repeat (4) @(posedge pclk);
        chk(32'(special_mode), 32'(hold));
    endtask

    task automatic test_normal;
        chk(32'(special_mode), 32'h0);
        xfer(8'h81, 8'h00);
        chk(rd & 32'h82, 32'h0);
        bkpt(2'h1);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask

    task automatic test_special;
        secured <= 1'b1;
        erased <= 1'b1;
        strap(1'b1);
        xfer(8'h81, 8'h00);
        chk(rd & 32'h82, 32'h82);
        bkpt(2'h2);
        chk(32'(debug_active), 32'h1);
        xfer(8'h01, 8'h00);
        chk(32'(debug_active), 32'h0);
        bkpt(2'h1);
    endtask

    task automatic test_regs;
        xfer(8'h06, 8'hA5);
        chk(32'(ccr_out), 32'hA5);
        xfer(8'h86, 8'h00);
        chk(rd & 32'hFF, 32'hA5);
        xfer(8'h08, 8'hFF);
        chk(32'(ppr_out), 32'h8F);
        erased <= 1'b0;
        xfer(8'h86, 8'h00);
        chk(rd & 32'hFF, 32'h0);
        xfer(8'h06, 8'h33);
        chk(32'(ccr_out), 32'hA5);
        erased <= 1'b1;
    endtask

    // host reset mid-command leaves the target with a partial command
    task automatic test_timeout;
        apb(1'b1, H_CTRL_OFS, {15'h0000, 1'b1, 8'h3C, 8'h06});
        repeat (600) @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4200) @(posedge pclk);
        xfer(8'h06, 8'h5A);
        chk(32'(ccr_out), 32'h5A);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        tgt_rstn = 1'b0;
        secured = 1'b0;
        erased = 1'b0;
        bkpt_req = 1'b0;
        bkpt_to_debug = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        num_errors = 0;
        checked = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        tgt_rstn <= 1'b1;
        test_normal;
        test_special;
        test_regs;
        test_timeout;
        close_out;
    end

    initial begin
        repeat (60000) @(posedge pclk);
        num_errors++;
        close_out;
    end
endmodule // sbdp_tb
`default_nettype wire
